/* File: tsi_irq_logic.sv */
// Purpose: interrupt request logic of the capacitive touch controller
// Assumes: serial interface hands over whole 16-bit words, address set-up strobes
// Notes:   request pin is open drain, only ever driven low
`timescale 1ns/1ns

// Behaviour
// R1 - request pin open drain, pulls low only
// R2 - completion and threshold sources, per-stage enables
// R3 - read clears at address set-up time
// R4 - enabled stage completion asserts request
// R5 - completion enable register, one bit per stage
// R6 - host enables completion only on last stage
// R7 - completion flags clear on read unless retriggered
// R8 - touch and release each raise request
// R9 - low and high threshold enable registers
// R10 - low and high threshold status readable
// R11 - threshold request held until both read
// R12 - any threshold status change raises request; the code counts changes on enabled stages only
// R13 - threshold status shows live activation
// R14 - registers are 16-bit words, upper byte first
// R15 - request is OR of pending enabled sources
module tsi_irq_logic (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // register port from the serial interface
  input  wire logic [9:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // events from the conversion sequencer and threshold engine
  input  wire logic [15:0] stage_done,
  input  wire logic [15:0] low_active,
  input  wire logic [15:0] high_active,
  // open-drain request pin
  input  wire logic        int_n_i,
  output logic             int_n_o,
  output logic             int_n_oe
);
  // ****************************************
  // declarations
  // ****************************************
  logic [15:0] low_en_r;
  logic [15:0] high_en_r;
  logic [15:0] done_en_r;
  logic [15:0] done_flags;
  logic [15:0] low_prev_r;
  logic [15:0] high_prev_r;
  logic        thr_pend_r;
  logic        seen_low_r;
  logic        seen_high_r;
  logic        irq_oe_r;
  logic [15:0] rdata_r;
  logic        rd_low;
  logic        rd_high;
  logic        rd_done;
  logic        thr_change;

  // ****************************************
  // register decode
  // ****************************************
  // reads act on the address strobe, not on the end of the byte transfer
  assign rd_low  = reg_rd && (reg_addr == tsi_pkg::OFF_LOW_FLAGS);  // see R3
  assign rd_high = reg_rd && (reg_addr == tsi_pkg::OFF_HIGH_FLAGS); // see R3
  assign rd_done = reg_rd && (reg_addr == tsi_pkg::OFF_DONE_FLAGS); // see R3

  // enable registers, whole-word writes only
  always_ff @(posedge clk) begin
    if (!rstn) begin
      low_en_r  <= tsi_pkg::EN_RST;
      high_en_r <= tsi_pkg::EN_RST;
      done_en_r <= tsi_pkg::EN_RST;
    end else if (reg_wr) begin
      if (reg_addr == tsi_pkg::OFF_LOW_EN) begin
        low_en_r <= reg_wdata; // see R9
      end
      if (reg_addr == tsi_pkg::OFF_HIGH_EN) begin
        high_en_r <= reg_wdata; // see R9
      end
      if (reg_addr == tsi_pkg::OFF_DONE_EN) begin
        done_en_r <= reg_wdata; // see R5
      end
    end
  end

  // ****************************************
  // completion source
  // ****************************************
  tsi_done_flags u_done (
    .clk        (clk),
    .rstn       (rstn),
    .stage_done (stage_done),
    .enable     (done_en_r),
    .clr        (rd_done),
    .flags_r    (done_flags)
  );

  // ****************************************
  // threshold source
  // ****************************************
  // a change on any enabled stage counts, so touch and lift-off both fire
  assign thr_change = |(((low_active ^ low_prev_r) & low_en_r) |
                        ((high_active ^ high_prev_r) & high_en_r)); // see R12

  // last seen activation, used only for change detection
  always_ff @(posedge clk) begin
    if (!rstn) begin
      low_prev_r  <= tsi_pkg::FLAGS_RST;
      high_prev_r <= tsi_pkg::FLAGS_RST;
    end else begin
      low_prev_r  <= low_active;
      high_prev_r <= high_active;
    end
  end

  // pending threshold request; a fresh change restarts the two-read handshake
  always_ff @(posedge clk) begin
    if (!rstn) begin
      thr_pend_r  <= 1'b0;
      seen_low_r  <= 1'b0;
      seen_high_r <= 1'b0;
    end else if (thr_change) begin
      thr_pend_r  <= 1'b1; // see R8
      seen_low_r  <= 1'b0;
      seen_high_r <= 1'b0;
    end else begin
      if (rd_low) begin
        seen_low_r <= 1'b1;
      end
      if (rd_high) begin
        seen_high_r <= 1'b1;
      end
      if ((seen_low_r || rd_low) && (seen_high_r || rd_high)) begin
        thr_pend_r  <= 1'b0; // see R11
        seen_low_r  <= 1'b0;
        seen_high_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // read data
  // ****************************************
  // flags are sampled before their clear takes effect; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_r <= tsi_pkg::RD_IDLE;
    end else if (reg_rd) begin
      case (reg_addr)
        tsi_pkg::OFF_LOW_EN:     rdata_r <= low_en_r;
        tsi_pkg::OFF_HIGH_EN:    rdata_r <= high_en_r;
        tsi_pkg::OFF_DONE_EN:    rdata_r <= done_en_r;
        tsi_pkg::OFF_LOW_FLAGS:  rdata_r <= low_active;  // see R10, R13
        tsi_pkg::OFF_HIGH_FLAGS: rdata_r <= high_active; // see R10, R13
        tsi_pkg::OFF_DONE_FLAGS: rdata_r <= done_flags;  // see R2
        default:                 rdata_r <= tsi_pkg::RD_IDLE;
      endcase
    end
  end
  assign reg_rdata = rdata_r; // see R14

  // ****************************************
  // request pin
  // ****************************************
  // one cycle behind the sources; the pin is never driven high
  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_oe_r <= 1'b0;
    end else begin
      irq_oe_r <= (|done_flags) || thr_pend_r; // see R15, R2
    end
  end
  assign int_n_o  = 1'b0;     // see R1
  assign int_n_oe = irq_oe_r; // see R1

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence seq_low_read;
    rd_low && !thr_change;
  endsequence
  sequence seq_high_last;
    rd_high && seen_low_r && !thr_change;
  endsequence
  // host may read the two status words in either order
  sequence seq_high_read;
    rd_high && !thr_change;
  endsequence
  sequence seq_low_last;
    rd_low && seen_high_r && !thr_change;
  endsequence

  chk_done_sets: assert property ((|(stage_done & done_en_r)) |=> (|done_flags) ##1 int_n_oe) // see R4
    else $error("completion did not raise request");
  chk_done_clear: assert property ((rd_done && !(|(stage_done & done_en_r))) |=> done_flags == 16'h0000) // see R7
    else $error("completion flags not cleared by read");
  chk_done_retain: assert property ((rd_done && (|(stage_done & done_en_r))) |=> (|done_flags)) // see R7
    else $error("retriggered completion lost on read");
  chk_thr_change: assert property (thr_change |=> thr_pend_r ##1 int_n_oe) // see R12
    else $error("threshold change did not raise request");
  chk_thr_hold: assert property ((thr_pend_r && !rd_high && !seen_high_r) |=> thr_pend_r) // see R11
    else $error("threshold request dropped before both reads");
  // a read strobe is one cycle, so the second read lands one or two cycles later
  chk_thr_release: assert property (seq_low_read ##[1:2] seq_high_last |=> !thr_pend_r) // see R11
    else $error("threshold request not released by both reads");
  chk_live_status: assert property (rd_low |=> reg_rdata == $past(low_active)) // see R13
    else $error("low status not live");
  chk_enable_write: assert property ((reg_wr && reg_addr == tsi_pkg::OFF_DONE_EN) |=>
                                     done_en_r == $past(reg_wdata)) // see R5
    else $error("completion enable write lost");
  chk_pin_quiet: assert property ((!(|done_flags) && !thr_pend_r) |=> !int_n_oe && int_n_o == 1'b0) // see R1
    else $error("request pin driven without cause");
  chk_thr_release_rev: assert property (seq_high_read ##[1:2] seq_low_last |=> !thr_pend_r) // see R11
    else $error("threshold request not released by reversed reads");
  chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata)) // see R10
    else $error("read data changed without a read");
  chk_done_quiet: assert property ((!(|(stage_done & done_en_r)) && !(|done_flags)) |=> !(|done_flags)) // see R4
    else $error("completion flag set without enabled completion");
endmodule

/* File: tsi_pkg.sv */
// Purpose: shared constants for the touch sensor interrupt logic
// Assumes: 10-bit register addresses, 16-bit register words
// Notes:   offsets are word indices as seen on the register port
package tsi_pkg;
  // ****************************************
  // widths
  // ****************************************
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [9:0] OFF_LOW_EN     = 10'h005;
  localparam logic [9:0] OFF_HIGH_EN    = 10'h006;
  localparam logic [9:0] OFF_DONE_EN    = 10'h007;
  localparam logic [9:0] OFF_LOW_FLAGS  = 10'h008;
  localparam logic [9:0] OFF_HIGH_FLAGS = 10'h009;
  localparam logic [9:0] OFF_DONE_FLAGS = 10'h00A;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] EN_RST    = 16'h0000;
  localparam logic [15:0] FLAGS_RST = 16'h0000;
  localparam logic [15:0] RD_IDLE   = 16'h0000;
endpackage

/* File: tsi_done_flags.sv */
// Purpose: sticky per-stage conversion-complete flags
// Assumes: stage_done pulses one cycle when a stage result is stored
// Notes:   a completion in the clearing cycle survives the clear
`timescale 1ns/1ns
module tsi_done_flags (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // events and control
  input  wire logic [15:0] stage_done,
  input  wire logic [15:0] enable,
  input  wire logic        clr,
  // state
  output logic      [15:0] flags_r
);
  // ****************************************
  // flag storage
  // ****************************************
  // one flop per stage; set beats clear so no completion is lost
  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : g_flag
      always_ff @(posedge clk) begin
        if (!rstn) begin
          flags_r[i] <= tsi_pkg::FLAGS_RST[i];
        end else if (stage_done[i] && enable[i]) begin // see R4
          flags_r[i] <= 1'b1; // see R7
        end else if (clr) begin
          flags_r[i] <= 1'b0; // see R7
        end
      end
    end
  endgenerate
endmodule

/* File: tsi_host.sv */
// Purpose: host side of the request pin
// Assumes: a pull-up on the board holds the line high
// Notes:   the host only ever watches the resolved level
`timescale 1ns/1ns
module tsi_host (
  // pin from the device
  input  wire logic int_n_o,
  input  wire logic int_n_oe,
  // resolved level seen by the host
  output logic      int_n_line
);
  // pull-up wins unless the device pulls low
  assign int_n_line = int_n_oe ? int_n_o : 1'b1;
endmodule

/* File: touch_sensor_irq_logic_tb_top.sv */
// Purpose: self-checking bench for the request logic
// Assumes: inputs change 5 ns after the rising edge
// Notes:   expected values come from the register map only
`timescale 1ns/1ns
module touch_sensor_irq_logic_tb_top;
  logic        clk, rstn, reg_wr, reg_rd, int_n_line, int_n_o, int_n_oe;
  logic [9:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, stage_done, low_active, high_active, got;
  int          miscompares, samples_checked;

  tsi_irq_logic dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stage_done(stage_done), .low_active(low_active),
    .high_active(high_active), .int_n_i(int_n_line), .int_n_o(int_n_o), .int_n_oe(int_n_oe));
  tsi_host host (.int_n_o(int_n_o), .int_n_oe(int_n_oe), .int_n_line(int_n_line));

  // ****************************************
  // helpers
  // ****************************************
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic line_is(input logic v);
    chk("request line", {15'h0000, v}, {15'h0000, int_n_line});
  endtask
  // strobe drops for a cycle so back-to-back calls never collide
  task automatic rd(input logic [9:0] a);
    reg_addr = a;
    reg_rd   = 1'b1;
    cyc(1);
    reg_rd   = 1'b0;
    cyc(1);
    got      = reg_rdata;
  endtask
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    cyc(1);
    reg_wr    = 1'b0;
    cyc(1);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    for (int a = 5; a < 12; a++) begin
      rd(a[9:0]);
      chk("reset read", 16'h0000, got);
    end
    line_is(1'b1);
  endtask
  task automatic t_done;
    wr(tsi_pkg::OFF_DONE_EN, 16'h0010);
    stage_done = 16'hFFFF;
    cyc(1);
    stage_done = 16'h0000;
    cyc(2);
    line_is(1'b0);
    rd(tsi_pkg::OFF_DONE_FLAGS);
    chk("done flags", 16'h0010, got);
    line_is(1'b1);
    // completion in the clearing cycle must survive
    reg_addr   = tsi_pkg::OFF_DONE_FLAGS;
    reg_rd     = 1'b1;
    stage_done = 16'h0010;
    cyc(1);
    reg_rd     = 1'b0;
    stage_done = 16'h0000;
    cyc(2);
    line_is(1'b0);
    rd(tsi_pkg::OFF_DONE_FLAGS);
    chk("done flags kept", 16'h0010, got);
    line_is(1'b1);
  endtask
  task automatic t_thresh;
    wr(tsi_pkg::OFF_LOW_EN, 16'h0001);
    wr(tsi_pkg::OFF_HIGH_EN, 16'h0002);
    low_active = 16'h0021;
    cyc(3);
    line_is(1'b0);
    rd(tsi_pkg::OFF_LOW_FLAGS);
    chk("low flags", 16'h0021, got);
    line_is(1'b0);
    rd(tsi_pkg::OFF_HIGH_FLAGS);
    chk("high flags", 16'h0000, got);
    cyc(1);
    line_is(1'b1);
    low_active = 16'h0001;
    cyc(3);
    line_is(1'b1);
    low_active = 16'h0000;
    cyc(3);
    line_is(1'b0);
    rd(tsi_pkg::OFF_HIGH_FLAGS);
    rd(tsi_pkg::OFF_LOW_FLAGS);
    cyc(1);
    line_is(1'b1);
    high_active = 16'h0002;
    cyc(3);
    line_is(1'b0);
    rd(tsi_pkg::OFF_HIGH_FLAGS);
    chk("high flags", 16'h0002, got);
    rd(tsi_pkg::OFF_LOW_FLAGS);
    cyc(1);
    line_is(1'b1);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog, far beyond the 60 or so cycles needed
  initial begin
    #100000;
    miscompares++;
    stop_test();
  end
  // main sequence
  initial begin
    rstn        = 1'b0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    reg_addr    = 10'h000;
    reg_wdata   = 16'h0000;
    stage_done  = 16'h0000;
    low_active  = 16'h0000;
    high_active = 16'h0000;
    cyc(3);
    rstn = 1'b1;
    t_reset();
    t_done();
    t_thresh();
    stop_test();
  end
endmodule
